// ==== core/osd_ctrl.v ====
// Display control register bank with shadow transfer, sync handling and line counter
`timescale 1ns/1ps
`include "osd_regs_defs.vh"
module osd_ctrl #(
   parameter AW = 9,
   parameter RASTERS_PER_LINE = 16
) (
   input wire clk,
   input wire reset,
   input wire [`OSD_AW-1:0] cpu_addr,
   input wire cpu_wr,
   input wire cpu_rd,
   input wire [7:0] cpu_wdata,
   output reg [7:0] cpu_rdata_q,
   input wire hsync_in,
   input wire vsync_in,
   input wire [AW-1:0] disp_rd_addr,
   input wire pix_fg,
   input wire pix_fringe,
   output wire [`OSD_CODE_W-1:0] disp_code_q,
   output wire [`OSD_ATTR_W-1:0] disp_attr_q,
   output reg [23:0] line_size_field_q,
   output reg [11:0] fringe_enable_bit_q,
   output reg [3:0] port6_video_select_q,
   output reg [7:0] window_top_q,
   output reg [7:0] window_bottom_q,
   output reg in_window_q,
   output reg blink_master_enable_q,
   output reg reverse_blink_master_enable_q,
   output reg smoothing_enable_q,
   output reg double_scan_select_q,
   output reg osc_freq_select_q,
   output reg display_enable_q,
   output reg video_r_q,
   output reg video_g_q,
   output reg video_b_q,
   output reg video_ybl_q,
   output reg disp_irq_q
);

   // Window limit in raster lines: two per step, four in double scan
   function [9:0] win_rasters(input [7:0] lim, input dbl);
      win_rasters = dbl ? {lim, 2'b00} : {1'b0, lim, 1'b0};
   endfunction

   function wr_hit(input [`OSD_AW-1:0] a, input [`OSD_AW-1:0] target, input we);
      wr_hit = we && (a == target);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Shadow copies, written by the CPU and moved on transfer
   reg [23:0] sh_size_q;
   reg [11:0] sh_fringe_q;
   reg [7:0] sh_top_q;
   reg [7:0] sh_bot_q;
   reg [7:0] sh_bk_q;
   reg [7:0] sh_rc_q;
   reg sh_display_enable_q;
   reg sh_window_enable_q;
   // Active copies driving the display
   reg [7:0] act_bk_q;
   reg [7:0] act_rc_q;
   reg act_window_enable_q;
   // Immediate settings
   reg ybl_sel_q;
   reg mem_bank_q;
   reg [AW-1:0] mem_addr_q;
   reg [`OSD_ATTR_W-1:0] attr_q;
   reg hsync_invert_q;
   reg vsync_invert_q;
   reg xfer_busy_q;

   wire wr_cs4 = wr_hit(cpu_addr, `OSD_A_CS4, cpu_wr);
   wire wr_cs8 = wr_hit(cpu_addr, `OSD_A_CS8, cpu_wr);
   wire wr_cs12 = wr_hit(cpu_addr, `OSD_A_CS12, cpu_wr);
   wire wr_efr = wr_hit(cpu_addr, `OSD_A_EFR, cpu_wr);
   wire wr_p6 = wr_hit(cpu_addr, `OSD_A_P6DS, cpu_wr);
   wire wr_top = wr_hit(cpu_addr, `OSD_A_WTOP, cpu_wr);
   wire wr_bot = wr_hit(cpu_addr, `OSD_A_WBOT, cpu_wr);
   wire wr_bk = wr_hit(cpu_addr, `OSD_A_BK, cpu_wr);
   wire wr_rc = wr_hit(cpu_addr, `OSD_A_RC, cpu_wr);
   wire wr_etc = wr_hit(cpu_addr, `OSD_A_ETC, cpu_wr);
   wire wr_dma = wr_hit(cpu_addr, `OSD_A_DMA, cpu_wr);
   wire wr_dsn = wr_hit(cpu_addr, `OSD_A_DSN, cpu_wr);
   wire wr_cra = wr_hit(cpu_addr, `OSD_A_CRA, cpu_wr);
   wire wr_don = wr_hit(cpu_addr, `OSD_A_DON, cpu_wr);
   wire wr_pol = wr_hit(cpu_addr, `OSD_A_POL, cpu_wr);

   ////////////////////////////////////////////////////////////////////////
   // Sync inputs: two flops, then polarity and edge detect
   reg hs_s1_q;
   reg hs_s2_q;
   reg vs_s1_q;
   reg vs_s2_q;
   reg hs_prev_q;
   reg vs_prev_q;
   wire hs_now = hs_s2_q ^ hsync_invert_q;
   wire vs_now = vs_s2_q ^ vsync_invert_q;
   // Edge taken against the raw pin, so a polarity write makes no false edge
   wire hs_fall = (hs_prev_q ^ hsync_invert_q) & ~hs_now;
   wire vs_fall = (vs_prev_q ^ vsync_invert_q) & ~vs_now;

   always @(posedge clk) begin
      if (reset) begin
         hs_s1_q <= 1'b1;
         hs_s2_q <= 1'b1;
         vs_s1_q <= 1'b1;
         vs_s2_q <= 1'b1;
         hs_prev_q <= 1'b1;
         vs_prev_q <= 1'b1;
      end else begin
         hs_s1_q <= hsync_in;
         hs_s2_q <= hs_s1_q;
         vs_s1_q <= vsync_in;
         vs_s2_q <= vs_s1_q;
         hs_prev_q <= hs_s2_q;
         vs_prev_q <= vs_s2_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // CPU writes to shadow and immediate registers
   wire mem_we_code = wr_cra;
   wire mem_we_attr = (wr_dsn & ~mem_bank_q) | (wr_cra & mem_bank_q);
   wire [`OSD_ATTR_W-1:0] mem_attr_d = wr_dsn ? cpu_wdata[`OSD_ATTR_W-1:0] : attr_q;

   always @(posedge clk) begin
      if (reset) begin
         sh_size_q <= 24'h000000;
         sh_fringe_q <= 12'h000;
         sh_top_q <= `OSD_RST_BYTE;
         sh_bot_q <= `OSD_RST_BYTE;
         sh_bk_q <= `OSD_RST_BYTE;
         sh_rc_q <= `OSD_RST_BYTE;
         sh_display_enable_q <= 1'b0;
         sh_window_enable_q <= 1'b0;
         port6_video_select_q <= 4'h0;
         ybl_sel_q <= 1'b0;
         blink_master_enable_q <= 1'b0;
         reverse_blink_master_enable_q <= 1'b0;
         smoothing_enable_q <= 1'b0;
         double_scan_select_q <= 1'b0;
         mem_bank_q <= 1'b0;
         mem_addr_q <= {AW{1'b0}};
         attr_q <= {`OSD_ATTR_W{1'b0}};
         osc_freq_select_q <= 1'b0;
         hsync_invert_q <= 1'b0;
         vsync_invert_q <= 1'b0;
      end else begin
         if (wr_cs4) sh_size_q[7:0] <= cpu_wdata;
         if (wr_cs8) sh_size_q[15:8] <= cpu_wdata;
         if (wr_cs12) sh_size_q[23:16] <= cpu_wdata;
         if (wr_efr) sh_fringe_q[7:0] <= cpu_wdata;
         if (wr_p6) begin
            sh_fringe_q[11:8] <= cpu_wdata[3:0];
            port6_video_select_q <= cpu_wdata[`OSD_P6_HI:`OSD_P6_LO];
         end
         if (wr_top) sh_top_q <= cpu_wdata;
         if (wr_bot) sh_bot_q <= cpu_wdata;
         if (wr_bk) sh_bk_q <= cpu_wdata;
         if (wr_rc) sh_rc_q <= cpu_wdata;
         if (wr_etc) begin
            ybl_sel_q <= cpu_wdata[`OSD_ETC_LUMA_BLANK_SELECT];
            blink_master_enable_q <= cpu_wdata[`OSD_ETC_BLINK_MASTER_ENABLE];
            reverse_blink_master_enable_q <= cpu_wdata[`OSD_ETC_REVERSE_BLINK_MASTER_ENABLE];
            smoothing_enable_q <= cpu_wdata[`OSD_ETC_SMOOTHING_ENABLE];
            double_scan_select_q <= cpu_wdata[`OSD_ETC_DOUBLE_SCAN_SELECT];
            mem_bank_q <= cpu_wdata[`OSD_ETC_MBK];
            mem_addr_q[AW-1] <= cpu_wdata[`OSD_ETC_MEM_ADDR_BIT8];
         end else if (wr_dma) begin
            mem_addr_q[AW-2:0] <= cpu_wdata[AW-2:0];
         end else if (mem_we_code | mem_we_attr) begin
            mem_addr_q <= mem_addr_q + {{(AW-1){1'b0}}, 1'b1};
         end
         if (wr_dsn) attr_q <= cpu_wdata[`OSD_ATTR_W-1:0];
         if (wr_don) begin
            sh_display_enable_q <= cpu_wdata[`OSD_DON_DISPLAY_ENABLE];
            sh_window_enable_q <= cpu_wdata[`OSD_DON_WINDOW_ENABLE];
            osc_freq_select_q <= cpu_wdata[`OSD_DON_OSC_FREQ_SELECT];
         end
         if (wr_pol) begin
            hsync_invert_q <= cpu_wdata[`OSD_POL_HD];
            vsync_invert_q <= cpu_wdata[`OSD_POL_VD];
         end
      end
   end

   osd_dmem #(
      .AW(AW),
      .CW(`OSD_CODE_W),
      .TW(`OSD_ATTR_W)
   ) u_dmem (
      .clk(clk),
      .we_code(mem_we_code),
      .we_attr(mem_we_attr),
      .wr_addr(mem_addr_q),
      .wr_code(cpu_wdata),
      .wr_attr(mem_attr_d),
      .rd_addr(disp_rd_addr),
      .rd_code_q(disp_code_q),
      .rd_attr_q(disp_attr_q)
   );

   ////////////////////////////////////////////////////////////////////////
   // Transfer request: copy at the next horizontal sync falling edge
   // A zero write is ignored so a stray clear cannot cancel a pending copy
   always @(posedge clk) begin
      if (reset) begin
         xfer_busy_q <= 1'b0;
      end else if (wr_don && cpu_wdata[`OSD_DON_TRANSFER_REQUEST]) begin
         xfer_busy_q <= 1'b1;
      end else if (hs_fall) begin
         xfer_busy_q <= 1'b0;
      end
   end

   always @(posedge clk) begin
      if (reset) begin
         line_size_field_q <= 24'h000000;
         fringe_enable_bit_q <= 12'h000;
         window_top_q <= `OSD_RST_BYTE;
         window_bottom_q <= `OSD_RST_BYTE;
         act_bk_q <= `OSD_RST_BYTE;
         act_rc_q <= `OSD_RST_BYTE;
         display_enable_q <= 1'b0;
         act_window_enable_q <= 1'b0;
      end else if (xfer_busy_q && hs_fall) begin
         line_size_field_q <= sh_size_q;
         fringe_enable_bit_q <= sh_fringe_q;
         window_top_q <= sh_top_q;
         window_bottom_q <= sh_bot_q;
         act_bk_q <= sh_bk_q;
         act_rc_q <= sh_rc_q;
         display_enable_q <= sh_display_enable_q;
         act_window_enable_q <= sh_window_enable_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Raster position, window and display line counter
   reg [9:0] raster_q;
   reg [7:0] sub_line_q;
   reg [3:0] line_cnt_q;
   reg irq_done_q;
   wire [9:0] win_lo = win_rasters(window_top_q, double_scan_select_q);
   wire [9:0] win_hi = win_rasters(window_bottom_q, double_scan_select_q);
   wire win_now = ~act_window_enable_q | ((raster_q >= win_lo) && (raster_q < win_hi));
   wire line_end = hs_fall && win_now && (sub_line_q == RASTERS_PER_LINE - 1);
   wire [3:0] line_next = vs_fall ? 4'h0 : line_cnt_q + 4'h1;
   wire [3:0] irq_line = act_rc_q[`OSD_RC_IRQ_LINE_SELECT_HI:`OSD_RC_IRQ_LINE_SELECT_LO];
   wire src_vsync = act_rc_q[`OSD_RC_SVD];

   always @(posedge clk) begin
      if (reset) begin
         raster_q <= 10'h000;
         sub_line_q <= 8'h00;
         line_cnt_q <= 4'h0;
         in_window_q <= 1'b0;
      end else begin
         in_window_q <= win_now;
         if (vs_fall) begin
            raster_q <= 10'h000;
            sub_line_q <= 8'h00;
            line_cnt_q <= 4'h0;
         end else if (hs_fall) begin
            if (raster_q != 10'h3FF) raster_q <= raster_q + 10'h001;
            if (line_end) begin
               sub_line_q <= 8'h00;
               line_cnt_q <= line_next;
            end else if (win_now) begin
               sub_line_q <= sub_line_q + 8'h01;
            end
         end
      end
   end

   // Off and blank lines still count: the counter ignores line contents
   always @(posedge clk) begin
      if (reset) begin
         disp_irq_q <= 1'b0;
         irq_done_q <= 1'b0;
      end else begin
         disp_irq_q <= 1'b0;
         if (src_vsync) begin
            disp_irq_q <= vs_fall;
         end else if ((vs_fall || line_end) && !irq_done_q && line_next == irq_line) begin
            disp_irq_q <= 1'b1;
         end
         if (vs_fall && !(line_next == irq_line && !src_vsync)) begin
            irq_done_q <= 1'b0;
         end else if ((vs_fall || line_end) && line_next == irq_line) begin
            irq_done_q <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Video outputs with polarity
   wire bg_on = act_bk_q[`OSD_BK_BACKGROUND_ENABLE] & win_now & display_enable_q;
   wire [2:0] fg_col = disp_attr_q[2:0];
   wire [2:0] fr_col = act_bk_q[`OSD_BK_FR_HI:`OSD_BK_FR_LO];
   wire [2:0] bg_col = act_bk_q[`OSD_BK_BG_HI:`OSD_BK_BG_LO];
   wire fg_on = pix_fg & display_enable_q;
   wire fr_on = pix_fringe & display_enable_q;
   wire [2:0] col = fg_on ? fg_col : (fr_on ? fr_col : (bg_on ? bg_col : 3'h0));
   wire luma = fg_on | fr_on;
   wire blank = act_bk_q[`OSD_BK_FULL_RASTER_BLANK_ENABLE] | luma | bg_on;
   wire [2:0] rgb_pol = {3{act_rc_q[`OSD_RC_COLOR_OUT_POLARITY]}};

   always @(posedge clk) begin
      if (reset) begin
         video_r_q <= 1'b0;
         video_g_q <= 1'b0;
         video_b_q <= 1'b0;
         video_ybl_q <= 1'b0;
      end else begin
         {video_r_q, video_g_q, video_b_q} <= col ^ rgb_pol;
         video_ybl_q <= ybl_sel_q ? (blank ^ act_rc_q[`OSD_RC_BLANK_OUT_POLARITY]) :
            (luma ^ act_rc_q[`OSD_RC_YIV]);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // CPU reads; write-only locations read as zero
   always @(posedge clk) begin
      if (reset) begin
         cpu_rdata_q <= 8'h00;
      end else if (cpu_rd) begin
         case (cpu_addr)
            `OSD_A_LINE_COUNTER: cpu_rdata_q <= {4'h0, line_cnt_q};
            `OSD_A_DON: cpu_rdata_q <= {3'h0, osc_freq_select_q, 1'b0, xfer_busy_q,
               act_window_enable_q, display_enable_q};
            `OSD_A_POL: cpu_rdata_q <= {6'h00, vsync_invert_q, hsync_invert_q};
            default: cpu_rdata_q <= 8'h00;
         endcase
      end
   end
endmodule

// ==== core/osd_regs_defs.vh ====
// Register addresses, field positions and reset values of the display control bank
`ifndef OSD_REGS_DEFS_VH
`define OSD_REGS_DEFS_VH
`define OSD_AW 12
`define OSD_A_CS4 12'hF8D
`define OSD_A_CS8 12'hF8E
`define OSD_A_CS12 12'hF8F
`define OSD_A_EFR 12'hF90
`define OSD_A_P6DS 12'hF91
`define OSD_A_WTOP 12'hF92
`define OSD_A_WBOT 12'hF93
`define OSD_A_BK 12'hF94
`define OSD_A_RC 12'hF95
`define OSD_A_LINE_COUNTER 12'hF95
`define OSD_A_ETC 12'hF96
`define OSD_A_DMA 12'hF97
`define OSD_A_DSN 12'hF98
`define OSD_A_CRA 12'hF99
`define OSD_A_DON 12'hF9A
`define OSD_A_POL 12'hF9B
`define OSD_RST_BYTE 8'h00
// Display on/off control
`define OSD_DON_DISPLAY_ENABLE 0
`define OSD_DON_WINDOW_ENABLE 1
`define OSD_DON_TRANSFER_REQUEST 2
`define OSD_DON_OSC_FREQ_SELECT 4
// Extended control
`define OSD_ETC_MEM_ADDR_BIT8 0
`define OSD_ETC_MBK 1
`define OSD_ETC_DOUBLE_SCAN_SELECT 3
`define OSD_ETC_SMOOTHING_ENABLE 4
`define OSD_ETC_REVERSE_BLINK_MASTER_ENABLE 5
`define OSD_ETC_BLINK_MASTER_ENABLE 6
`define OSD_ETC_LUMA_BLANK_SELECT 7
// Background / fringe colour
`define OSD_BK_BG_HI 7
`define OSD_BK_BG_LO 5
`define OSD_BK_BACKGROUND_ENABLE 4
`define OSD_BK_FULL_RASTER_BLANK_ENABLE 3
`define OSD_BK_FR_HI 2
`define OSD_BK_FR_LO 0
// Output polarity and interrupt control
`define OSD_RC_BLANK_OUT_POLARITY 7
`define OSD_RC_YIV 6
`define OSD_RC_COLOR_OUT_POLARITY 5
`define OSD_RC_SVD 4
`define OSD_RC_IRQ_LINE_SELECT_HI 3
`define OSD_RC_IRQ_LINE_SELECT_LO 0
// Sync polarity
`define OSD_POL_HD 0
`define OSD_POL_VD 1
// Port six select field
`define OSD_P6_HI 7
`define OSD_P6_LO 4
// Attribute field and memory word
`define OSD_ATTR_W 6
`define OSD_CODE_W 8
`endif

// ==== core/osd_dmem.v ====
// Display memory: character code and attribute halves with separate write enables
`timescale 1ns/1ps
module osd_dmem #(
   parameter AW = 9,
   parameter CW = 8,
   parameter TW = 6
) (
   clk,
   we_code,
   we_attr,
   wr_addr,
   wr_code,
   wr_attr,
   rd_addr,
   rd_code_q,
   rd_attr_q
);
   input wire clk;
   input wire we_code;
   input wire we_attr;
   input wire [AW-1:0] wr_addr;
   input wire [CW-1:0] wr_code;
   input wire [TW-1:0] wr_attr;
   input wire [AW-1:0] rd_addr;
   output reg [CW-1:0] rd_code_q;
   output reg [TW-1:0] rd_attr_q;

   reg [CW-1:0] code_mem [0:(1<<AW)-1];
   reg [TW-1:0] attr_mem [0:(1<<AW)-1];

   always @(posedge clk) begin
      if (we_code) begin
         code_mem[wr_addr] <= wr_code;
      end
      if (we_attr) begin
         attr_mem[wr_addr] <= wr_attr;
      end
      rd_code_q <= code_mem[rd_addr];
      rd_attr_q <= attr_mem[rd_addr];
   end
endmodule

// ==== tb/osd_ctrl_checker.sv ====
// Concurrent checks on the ports of the display control bank
`timescale 1ns/1ps
`include "osd_regs_defs.vh"
module osd_ctrl_checker #(
   parameter AW = 9,
   parameter RASTERS_PER_LINE = 16
) (
   input wire clk,
   input wire reset,
   input wire [`OSD_AW-1:0] cpu_addr,
   input wire cpu_wr,
   input wire cpu_rd,
   input wire [7:0] cpu_wdata,
   input wire [7:0] cpu_rdata_q,
   input wire hsync_in,
   input wire [AW-1:0] disp_rd_addr,
   input wire [`OSD_CODE_W-1:0] disp_code_q,
   input wire [23:0] line_size_field_q,
   input wire [3:0] port6_video_select_q,
   input wire blink_master_enable_q,
   input wire reverse_blink_master_enable_q,
   input wire smoothing_enable_q,
   input wire double_scan_select_q,
   input wire osc_freq_select_q,
   input wire disp_irq_q
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   logic [7:0] wd_q;
   logic [1:0] pol_q;
   always @(posedge clk) begin
      wd_q <= cpu_wdata;
      if (reset)
         pol_q <= 2'b00;
      else if (cpu_wr && cpu_addr == `OSD_A_POL)
         pol_q <= cpu_wdata[1:0];
   end
   ////////////////////////////////////////////////////////////////////////////////
   // Only a long quiet hsync rules out a copy landing on the same edge
   sequence s_quiet_h;
      $stable(hsync_in) [*4];
   endsequence
   sequence s_size_wr;
      cpu_wr && cpu_addr == `OSD_A_CS4;
   endsequence
   sequence s_mem_idle;
      (!cpu_wr && $stable(disp_rd_addr)) [*3];
   endsequence
   a_irq_pulse: assert property (disp_irq_q |=> !disp_irq_q)
      else $error("interrupt pulse longer than one cycle");
   a_read_zero: assert property (cpu_rd && cpu_addr != `OSD_A_LINE_COUNTER &&
      cpu_addr != `OSD_A_DON && cpu_addr != `OSD_A_POL |=> cpu_rdata_q == 8'h00)
      else $error("write-only or unmapped read not zero");
   a_port6_now: assert property (cpu_wr && cpu_addr == `OSD_A_P6DS |=>
      port6_video_select_q == wd_q[7:4])
      else $error("port select not immediate");
   a_ext_now: assert property (cpu_wr && cpu_addr == `OSD_A_ETC |=>
      {blink_master_enable_q, reverse_blink_master_enable_q, smoothing_enable_q,
      double_scan_select_q} == wd_q[6:3])
      else $error("extended control not immediate");
   a_osc_freq_select_now: assert property (cpu_wr && cpu_addr == `OSD_A_DON |=>
      osc_freq_select_q == wd_q[4])
      else $error("frequency select not immediate");
   a_pol_back: assert property (cpu_rd && cpu_addr == `OSD_A_POL |=>
      cpu_rdata_q[1:0] == pol_q)
      else $error("sync polarity readback wrong");
   a_shadow_hold: assert property (s_quiet_h ##0 s_size_wr |=>
      $stable(line_size_field_q))
      else $error("size copy changed without transfer");
   a_mem_stable: assert property (s_mem_idle |=> $stable(disp_code_q))
      else $error("memory read data moved while idle");
endmodule

// ==== tb/osd_sync_model.sv ====
// Video sync source driving the horizontal and vertical sync pins
`timescale 1ns/1ps
module osd_sync_model (
   input wire clk,
   output logic hsync_in,
   output logic vsync_in
);
   initial begin
      hsync_in = 1'b1;
      vsync_in = 1'b1;
   end
   // Pins idle high; a long low time models a slow source
   task hpulse(input integer lo);
      begin
         @(posedge clk);
         hsync_in <= 1'b0;
         repeat (lo) @(posedge clk);
         hsync_in <= 1'b1;
         repeat (4) @(posedge clk);
      end
   endtask
   task vpulse(input integer lo);
      begin
         @(posedge clk);
         vsync_in <= 1'b0;
         repeat (lo) @(posedge clk);
         vsync_in <= 1'b1;
         repeat (4) @(posedge clk);
      end
   endtask
endmodule

// ==== tb/testbench.sv ====
// Self-checking bench for the display control register bank
`timescale 1ns/1ps
module testbench;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic [11:0] cpu_addr;
   logic cpu_wr;
   logic cpu_rd;
   logic [7:0] cpu_wdata;
   logic [8:0] disp_rd_addr;
   logic pix_fg;
   logic pix_fringe;
   wire hsync_in, vsync_in, bme, rbme, sme, dss, ofs, den, irq, vr, vg, vb, inwin, ybl;
   wire [7:0] cpu_rdata_q, disp_code_q, wtop, wbot;
   wire [5:0] disp_attr_q;
   wire [23:0] lsize;
   wire [11:0] fren;
   wire [3:0] p6;
   integer num_errors = 0;
   integer num_checks = 0;
   integer irq_cnt = 0;
   always #5 clk = ~clk;
   always @(posedge clk) if (irq === 1'b1) irq_cnt <= irq_cnt + 1;
   osd_sync_model i_sync (.clk(clk), .hsync_in(hsync_in), .vsync_in(vsync_in));
   osd_ctrl #(.AW(9), .RASTERS_PER_LINE(2)) i_dut (
      .clk(clk), .reset(reset), .cpu_addr(cpu_addr), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd),
      .cpu_wdata(cpu_wdata), .cpu_rdata_q(cpu_rdata_q), .hsync_in(hsync_in),
      .vsync_in(vsync_in), .disp_rd_addr(disp_rd_addr), .pix_fg(pix_fg),
      .pix_fringe(pix_fringe), .disp_code_q(disp_code_q), .disp_attr_q(disp_attr_q),
      .line_size_field_q(lsize), .fringe_enable_bit_q(fren), .port6_video_select_q(p6),
      .window_top_q(wtop), .window_bottom_q(wbot), .in_window_q(inwin),
      .blink_master_enable_q(bme), .reverse_blink_master_enable_q(rbme),
      .smoothing_enable_q(sme), .double_scan_select_q(dss), .osc_freq_select_q(ofs),
      .display_enable_q(den), .video_r_q(vr), .video_g_q(vg), .video_b_q(vb),
      .video_ybl_q(ybl), .disp_irq_q(irq));
   ////////////////////////////////////////////////////////////////////////////////
   // Plain stores only, never read-modify-write
   task wr(input [11:0] a, input [7:0] d);
      begin
         @(posedge clk);
         cpu_addr <= a;
         cpu_wdata <= d;
         cpu_wr <= 1'b1;
         @(posedge clk);
         cpu_wr <= 1'b0;
         #1;
      end
   endtask
   task rd(input [11:0] a, output logic [7:0] d);
      begin
         @(posedge clk);
         cpu_addr <= a;
         cpu_rd <= 1'b1;
         @(posedge clk);
         cpu_rd <= 1'b0;
         #1;
         d = cpu_rdata_q;
      end
   endtask
   task chk(input string n, input logic [23:0] e, input logic [23:0] g);
      begin
         num_checks = num_checks + 1;
         if (g !== e) begin
            num_errors = num_errors + 1;
            $display("[ERR] %s expected %h seen %h", n, e, g);
         end
      end
   endtask
   task rdchk(input string n, input [11:0] a, input [7:0] e);
      logic [7:0] v;
      begin
         rd(a, v);
         chk(n, e, v);
      end
   endtask
   task peek(input [8:0] a);
      begin
         @(posedge clk);
         disp_rd_addr <= a;
         repeat (2) @(posedge clk);
         #1;
      end
   endtask
   task pix(input f, input r);
      begin
         @(posedge clk);
         pix_fg <= f;
         pix_fringe <= r;
         repeat (2) @(posedge clk);
         #1;
      end
   endtask
   task report_and_stop;
      begin
         $display("checks %0d errors %0d", num_checks, num_errors);
         if (num_errors == 0 && num_checks > 0)
            $display("bench passed");
         else
            $display("bench failed");
         $finish;
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task t_reset;
      logic [7:0] v;
      begin
         chk("reset outs", 24'h0, {lsize[11:0], p6, den, irq, ofs});
         rdchk("status rst", 12'hF9A, 8'h00);
         rdchk("wo read", 12'hF8D, 8'h00);
         rdchk("unmapped", 12'hF00, 8'h00);
         rd(12'hF9B, v);
         chk("pol rst", 2'b00, v[1:0]);
      end
   endtask
   task t_immediate;
      begin
         wr(12'hF91, 8'hA5);
         chk("port6 sel", 4'hA, p6);
         chk("fringe held", 12'h000, fren);
         wr(12'hF96, 8'h78);
         chk("ext ctl", 4'hF, {bme, rbme, sme, dss});
         wr(12'hF9A, 8'h1C);
         chk("freq sel", 1'b1, ofs);
         rdchk("busy", 12'hF9A, 8'h14);
         i_sync.hpulse(4);
         rdchk("done", 12'hF9A, 8'h10);
         chk("fringe hi", 12'h500, fren);
      end
   endtask
   task t_transfer;
      begin
         wr(12'hF8D, 8'hE4);
         wr(12'hF90, 8'h0F);
         wr(12'hF92, 8'h01);
         wr(12'hF93, 8'hFE);
         wr(12'hF9A, 8'h0F);
         chk("size held", 24'h0, lsize);
         repeat (3) @(posedge clk);
         rdchk("busy", 12'hF9A, 8'h04);
         i_sync.hpulse(4);
         chk("size copy", 24'h0000E4, lsize);
         chk("fringe lo", 12'h50F, fren);
         chk("window", 16'h01FE, {wtop, wbot});
         rdchk("done", 12'hF9A, 8'h03);
      end
   endtask
   task t_sync_invert;
      logic [7:0] v;
      begin
         wr(12'hF9B, 8'h01);
         rd(12'hF9B, v);
         chk("pol back", 2'b01, v[1:0]);
         wr(12'hF8E, 8'h1B);
         wr(12'hF9A, 8'h0F);
         repeat (6) @(posedge clk);
         rdchk("idle pin", 12'hF9A, 8'h07);
         i_sync.hpulse(4);
         chk("inv copy", 24'h001BE4, lsize);
         wr(12'hF9B, 8'h00);
      end
   endtask
   task t_irq;
      integer n;
      logic [7:0] v;
      begin
         wr(12'hF95, 8'h10);
         wr(12'hF9A, 8'h0D);
         i_sync.hpulse(4);
         n = irq_cnt;
         i_sync.vpulse(8);
         chk("vsync irq", 1, irq_cnt - n);
         wr(12'hF95, 8'h03);
         wr(12'hF9A, 8'h0D);
         i_sync.hpulse(4);
         n = irq_cnt;
         i_sync.vpulse(8);
         repeat (6) i_sync.hpulse(4);
         rd(12'hF95, v);
         chk("line count", 4'h3, v[3:0]);
         repeat (2) i_sync.hpulse(4);
         chk("line irq", 1, irq_cnt - n);
      end
   endtask
   task t_mem;
      begin
         wr(12'hF97, 8'h05);
         wr(12'hF96, 8'h00);
         wr(12'hF99, 8'h3C);
         wr(12'hF99, 8'h5A);
         peek(9'h005);
         chk("code 5", 8'h3C, disp_code_q);
         peek(9'h006);
         chk("code 6", 8'h5A, disp_code_q);
         wr(12'hF97, 8'h10);
         wr(12'hF96, 8'h02);
         wr(12'hF98, 8'h2B);
         wr(12'hF99, 8'hC3);
         peek(9'h010);
         chk("both", 14'h30EB, {disp_code_q, disp_attr_q});
         wr(12'hF97, 8'h20);
         wr(12'hF96, 8'h00);
         wr(12'hF98, 8'h15);
         wr(12'hF99, 8'h77);
         peek(9'h020);
         chk("attr only", 6'h15, disp_attr_q);
         peek(9'h021);
         chk("after attr", 8'h77, disp_code_q);
         wr(12'hF97, 8'hFF);
         wr(12'hF96, 8'h01);
         wr(12'hF99, 8'h99);
         peek(9'h1FF);
         chk("bit8 addr", 8'h99, disp_code_q);
      end
   endtask
   task t_video;
      begin
         chk("rgb high", 3'b000, {vr, vg, vb});
         wr(12'hF95, 8'hE3);
         wr(12'hF9A, 8'h0D);
         i_sync.hpulse(4);
         chk("rgb low", 3'b111, {vr, vg, vb});
         chk("in window", 1'b1, inwin);
         wr(12'hF94, 8'hD3);
         wr(12'hF9A, 8'h0D);
         i_sync.hpulse(4);
         peek(9'h020);
         pix(1'b0, 1'b0);
         chk("bg yellow", 4'h3, {vr, vg, vb, ybl});
         pix(1'b0, 1'b1);
         chk("fringe cyan", 4'h8, {vr, vg, vb, ybl});
         pix(1'b1, 1'b0);
         chk("char magenta", 4'h4, {vr, vg, vb, ybl});
         wr(12'hF96, 8'h80);
         pix(1'b0, 1'b0);
         chk("blank out", 4'h2, {vr, vg, vb, ybl});
      end
   endtask
   initial begin
      cpu_addr <= 12'h000;
      cpu_wdata <= 8'h00;
      disp_rd_addr <= 9'h000;
      {cpu_wr, cpu_rd, pix_fg, pix_fringe} <= 4'h0;
      repeat (20) @(posedge clk);
      reset <= 1'b0;
      t_reset;
      t_immediate;
      t_transfer;
      t_sync_invert;
      t_irq;
      t_mem;
      t_video;
      report_and_stop;
   end
   initial begin
      repeat (20000) @(posedge clk);
      num_errors = num_errors + 1;
      report_and_stop;
   end
endmodule
bind osd_ctrl osd_ctrl_checker #(.AW(AW), .RASTERS_PER_LINE(RASTERS_PER_LINE)) i_chk (
   .clk(clk), .reset(reset), .cpu_addr(cpu_addr), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd),
   .cpu_wdata(cpu_wdata), .cpu_rdata_q(cpu_rdata_q), .hsync_in(hsync_in),
   .disp_rd_addr(disp_rd_addr), .disp_code_q(disp_code_q),
   .line_size_field_q(line_size_field_q), .port6_video_select_q(port6_video_select_q),
   .blink_master_enable_q(blink_master_enable_q),
   .reverse_blink_master_enable_q(reverse_blink_master_enable_q),
   .smoothing_enable_q(smoothing_enable_q), .double_scan_select_q(double_scan_select_q),
   .osc_freq_select_q(osc_freq_select_q), .disp_irq_q(disp_irq_q));
